//--- rtl/isp_device.sv
// device end: serial slave register port with sample timer and backup engine
// assumes link pins are asynchronous to mclk and are sampled through two flops
`timescale 1ns/10ps
//
// How it works
// - runs samples at 819.2 SPS after reset
// - each sample loads outputs, pulses data-ready
// - only answers master transfers, never starts one
// - data out changes on clock falling edge
// - data in sampled on clock rising edge
// - 16-bit frames, MSB first, mode 3
// - master keeps serial clock under mode limits
// - separate 7-bit addresses for each byte
// - read: command frame then collecting frame
// - next frame returns addressed word, bit 15 first
// - full duplex: reply while taking next command
// - top bit one writes one byte, the upper byte when the address is odd
// - write lands only at frame end
// - frame 0xBE01 backs up user registers
// - backup takes 50 ms
// - backup count increments per backup
// - aux line is io or sync input

module isp_device
  #(
    parameter int SAMPLE_CYC = isp_pkg::SAMPLE_CYCLES, // default sample period in mclk
    parameter int BACKUP_CYC = isp_pkg::BACKUP_CYCLES  // backup duration in mclk
  )
  (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // serial link
    isp_link_if.dev link,
    // auxiliary io or sync clock pin
    input wire logic aux_in,
    output logic aux_out,
    output logic aux_oe_n,
    // status seen by the system
    output logic backup_busy,
    output logic [15:0] sample_count
  );
  import isp_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [1:0] sclk_sync_ff;  // [0] is read only by [1]
  logic [1:0] cs_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic [1:0] aux_sync_ff;
  logic sclk_prev_ff;        // last synchronised clock level
  logic aux_prev_ff;         // last synchronised aux level

  // two flops per pin; the link is asynchronous to mclk
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sclk_sync_ff <= 2'h3;
      cs_sync_ff <= 2'h3;
      mosi_sync_ff <= 2'h0;
      aux_sync_ff <= 2'h0;
      sclk_prev_ff <= 1'b1;
      aux_prev_ff <= 1'b0;
    end
    else
    begin
      sclk_sync_ff <= {sclk_sync_ff[0], link.sclk};
      cs_sync_ff <= {cs_sync_ff[0], link.cs_n};
      mosi_sync_ff <= {mosi_sync_ff[0], link.mosi};
      aux_sync_ff <= {aux_sync_ff[0], aux_in};
      sclk_prev_ff <= sclk_sync_ff[1];
      aux_prev_ff <= aux_sync_ff[1];
    end
  end

  logic sclk_rise;  // rising edge seen inside a frame
  logic sclk_fall;  // falling edge seen inside a frame
  logic selected;   // chip select asserted
  logic aux_rise;   // sync clock edge
  assign selected = !cs_sync_ff[1];
  assign sclk_rise = selected && sclk_sync_ff[1] && !sclk_prev_ff;
  assign sclk_fall = selected && !sclk_sync_ff[1] && sclk_prev_ff;
  assign aux_rise = aux_sync_ff[1] && !aux_prev_ff;

  // ------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------
  logic [3:0] bit_cnt_ff;   // bits taken in this frame
  logic [15:0] rx_sh_ff;    // incoming frame
  logic [15:0] tx_sh_ff;    // outgoing frame
  logic [15:0] tx_word_ff;  // word to send in the next frame
  logic miso_ff;
  logic frame_done;         // sixteenth rising edge
  logic [15:0] frame;       // complete incoming frame
  assign frame_done = sclk_rise && (bit_cnt_ff == 4'hF);
  assign frame = {rx_sh_ff[14:0], mosi_sync_ff[1]};

  // the port is passive: every shift is caused by the master's clock
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      bit_cnt_ff <= 4'h0;
      rx_sh_ff <= 16'h0000;
    end
    else if (!selected)
    begin
      bit_cnt_ff <= 4'h0;
    end
    else if (sclk_rise)
    begin
      rx_sh_ff <= frame;                         // msb first
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  // output side: load while deselected, shift on every falling edge
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tx_sh_ff <= 16'h0000;
      miso_ff <= 1'b0;
    end
    else if (!selected)
    begin
      tx_sh_ff <= tx_word_ff; // reply to the previous command
    end
    else if (sclk_fall)
    begin
      miso_ff <= tx_sh_ff[15];                   // bit 15 first
      tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
    end
  end
  assign link.miso = miso_ff;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [15:0] regs_ff [REG_WORDS];   // user registers, one word per even address
  logic [15:0] nv_ff [REG_WORDS];     // nonvolatile backup image
  logic [6:0] rd_addr;                // read address, byte granular
  logic [5:0] wr_addr;                // write address
  logic wr_frame;
  logic backup_req;
  logic sample_tick;                  // end of a sample cycle
  logic backup_end;                   // backup time has run out
  logic [15:0] sample_cnt_ff;
  assign rd_addr = frame[ADDR_MSB:ADDR_LSB];
  assign wr_addr = frame[WADDR_MSB:ADDR_LSB];
  assign wr_frame = frame_done && frame[RW_BIT];
  assign backup_req = frame_done && (frame == BACKUP_FRAME);

  // read command picks the word for the next frame; upper half of map reads zero
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tx_word_ff <= 16'h0000;
    end
    else if (frame_done && !frame[RW_BIT])
    begin
      // both byte addresses of a word return the whole word
      tx_word_ff <= rd_addr[6] ? 16'h0000 : regs_ff[rd_addr[5:1]];
    end
    else if (frame_done)
    begin
      tx_word_ff <= 16'h0000; // a write returns nothing next frame
    end
  end

  // one writer for the whole map: samples, backup count and host writes
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < REG_WORDS; i++)
      begin
        regs_ff[i] <= 16'h0000;
      end
      regs_ff[ADDR_MSC_CTRL[5:1]] <= RST_MSC_CTRL;
      regs_ff[ADDR_SAMPLE_PERIOD[5:1]] <= RST_SAMPLE_PERIOD;
      regs_ff[ADDR_SENS_AVG[5:1]] <= RST_SENS_AVG;
    end
    else
    begin
      if (sample_tick)
      begin
        // new-data flag on top, running sample count as data
        regs_ff[ADDR_X_ACCEL[5:1]] <= {2'h2, sample_cnt_ff[13:0]};
      end
      if (backup_end)
      begin
        regs_ff[ADDR_BACKUP_COUNT[5:1]] <= regs_ff[ADDR_BACKUP_COUNT[5:1]] + 16'h0001;
      end
      // byte write only at frame end; read-only and command words are not stored
      if (wr_frame && ({1'b0, wr_addr} >= ADDR_CFG_FIRST)
          && ({1'b0, wr_addr[5:1], 1'b0} != ADDR_GLOBAL_CMD))
      begin
        if (wr_addr[0])
        begin
          regs_ff[wr_addr[5:1]][15:8] <= frame[7:0];
        end
        else
        begin
          regs_ff[wr_addr[5:1]][7:0] <= frame[7:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // nonvolatile backup
  // ------------------------------------------------------------
  logic [21:0] backup_cnt_ff;  // cycles left in the backup
  logic backup_busy_ff;

  // image is taken at the command; the busy time models the slow cell write
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      backup_busy_ff <= 1'b0;
      backup_cnt_ff <= 22'h0;
    end
    else if (backup_req && !backup_busy_ff)
    begin
      backup_busy_ff <= 1'b1;
      backup_cnt_ff <= 22'(BACKUP_CYC - 1);
    end
    else if (backup_busy_ff)
    begin
      backup_cnt_ff <= backup_cnt_ff - 22'h1;
      if (backup_cnt_ff == 22'h0)
      begin
        backup_busy_ff <= 1'b0;
      end
    end
  end
  assign backup_end = backup_busy_ff && (backup_cnt_ff == 22'h0);
  assign backup_busy = backup_busy_ff;

  // copy of every user word; a command during a running backup is dropped
  always_ff @(posedge mclk)
  begin
    if (backup_req && !backup_busy_ff && !reset)
    begin
      nv_ff <= regs_ff;
    end
  end

  // ------------------------------------------------------------
  // sample timer, sync clock and aux line
  // ------------------------------------------------------------
  logic [15:0] base_cnt_ff;   // cycles within one base period
  logic [7:0] period_cnt_ff;  // base periods within one sample
  logic sync_mode;
  logic [7:0] period_set;
  logic base_tick;
  assign sync_mode = regs_ff[ADDR_GPIO_CTRL[5:1]][GPIO_SYNC_EN_BIT];
  assign period_set = regs_ff[ADDR_SAMPLE_PERIOD[5:1]][7:0];
  assign base_tick = (base_cnt_ff == 16'(SAMPLE_CYC - 1));

  // free running from reset, no command needed
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      base_cnt_ff <= 16'h0000;
      period_cnt_ff <= 8'h00;
    end
    else if (base_tick)
    begin
      base_cnt_ff <= 16'h0000;
      // setting of 0 is treated as 1 so the timer never stalls
      period_cnt_ff <= (period_cnt_ff + 8'h01 >= period_set) ? 8'h00 : period_cnt_ff + 8'h01;
    end
    else
    begin
      base_cnt_ff <= base_cnt_ff + 16'h0001;
    end
  end
  // in sync mode the external clock replaces the internal timer
  assign sample_tick = sync_mode ? aux_rise
                     : (base_tick && (period_cnt_ff + 8'h01 >= period_set));

  logic [3:0] drdy_cnt_ff;  // remaining cycles of the data-ready pulse
  logic drdy_ff;
  logic aux_out_ff;
  logic aux_oe_n_ff;

  // stretched pulse so a master on its own clock cannot miss it
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      drdy_cnt_ff <= 4'h0;
      drdy_ff <= 1'b0;
      sample_cnt_ff <= 16'h0000;
    end
    else if (sample_tick)
    begin
      drdy_ff <= 1'b1;
      drdy_cnt_ff <= 4'(DRDY_PULSE_CYCLES - 1);
      sample_cnt_ff <= sample_cnt_ff + 16'h0001;
    end
    else if (drdy_cnt_ff != 4'h0)
    begin
      drdy_cnt_ff <= drdy_cnt_ff - 4'h1;
    end
    else
    begin
      drdy_ff <= 1'b0;
    end
  end
  assign link.data_ready_line = drdy_ff;
  assign sample_count = sample_cnt_ff;

  // aux line drives only as a general output and never while it is the sync input
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      aux_out_ff <= 1'b0;
      aux_oe_n_ff <= 1'b1;
    end
    else
    begin
      aux_out_ff <= regs_ff[ADDR_GPIO_CTRL[5:1]][GPIO_AUX_LEVEL_BIT];
      aux_oe_n_ff <= !(regs_ff[ADDR_GPIO_CTRL[5:1]][GPIO_AUX_DIR_BIT] && !sync_mode);
    end
  end
  assign aux_out = aux_out_ff;
  assign aux_oe_n = aux_oe_n_ff;

endmodule

//--- rtl/isp_pkg.sv
// package for the inertial sensor serial register port, shared by both ends
// assumes a 40 MHz mclk on each end and a 16-bit mode 3 serial link between them

package isp_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40000000;          // mclk rate
  localparam int CLK_NS = 25;                // mclk period in ns
  localparam int SAMPLE_RATE_DSPS = 8192;    // default rate, tenths of a sample per second
  localparam int SAMPLE_CYCLES = (CLK_HZ * 10) / SAMPLE_RATE_DSPS; // rounded down
  localparam int BACKUP_MS = 50;             // nonvolatile backup duration
  localparam int BACKUP_CYCLES = (CLK_HZ / 1000) * BACKUP_MS;
  localparam int DRDY_PULSE_CYCLES = 8;      // long enough for a two-flop sampler
  localparam int SCLK_MAX_KHZ = 2000;        // fastest serial clock in normal mode
  localparam int SCLK_HALF_CYCLES = (CLK_HZ / 1000 / SCLK_MAX_KHZ + 1) / 2; // 10
  localparam int CS_SETUP_NS = 49;           // chip select to first edge, rounded up
  localparam int CS_SETUP_CYCLES = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STALL_NS = 9000;            // gap between frames
  localparam int STALL_CYCLES = (STALL_NS + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int RW_BIT = 15;                // 1 = write, 0 = read
  localparam int ADDR_MSB = 14;              // read address REGISTER_ADDRESS_FIELD at 14:8
  localparam int WADDR_MSB = 13;             // write address A5..A0 at 13:8
  localparam int ADDR_LSB = 8;
  localparam logic [15:0] BACKUP_FRAME = 16'hBE01;

  // ------------------------------------------------------------
  // register map (byte addresses of lower bytes)
  // ------------------------------------------------------------
  localparam int REG_WORDS = 32;
  localparam logic [6:0] ADDR_BACKUP_COUNT = 7'h00;
  localparam logic [6:0] ADDR_X_ACCEL = 7'h0A;
  localparam logic [6:0] ADDR_CFG_FIRST = 7'h1A;    // first writable byte
  localparam logic [6:0] ADDR_GPIO_CTRL = 7'h32;
  localparam logic [6:0] ADDR_MSC_CTRL = 7'h34;
  localparam logic [6:0] ADDR_SAMPLE_PERIOD = 7'h36;
  localparam logic [6:0] ADDR_SENS_AVG = 7'h38;
  localparam logic [6:0] ADDR_GLOBAL_CMD = 7'h3E;
  localparam logic [15:0] RST_MSC_CTRL = 16'h0006;
  localparam logic [15:0] RST_SAMPLE_PERIOD = 16'h0001;
  localparam logic [15:0] RST_SENS_AVG = 16'h0402;
  localparam int GPIO_AUX_DIR_BIT = 3;       // aux line drives when set and the sync bit is clear
  localparam int GPIO_AUX_LEVEL_BIT = 11;    // level driven on aux line
  localparam int GPIO_SYNC_EN_BIT = 4;       // aux line is the sync clock when set

  // ------------------------------------------------------------
  // master sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ISP_M_IDLE = 3'b000,
    ISP_M_SETUP = 3'b001,
    ISP_M_LOW = 3'b010,
    ISP_M_HIGH = 3'b011,
    ISP_M_STALL = 3'b100
  } isp_mstate_t;

endpackage

//--- rtl/isp_link_if.sv
// serial link between the sensor port and its master
// assumes the bench joins the two ends through one instance of this interface
`timescale 1ns/10ps

interface isp_link_if;
  logic sclk;            // serial clock, idles high, made by the master
  logic cs_n;            // chip select, active low
  logic mosi;            // master to device data
  logic miso;            // device to master data
  logic data_ready_line; // new-data-ready pulse from device

  modport dev (input sclk, input cs_n, input mosi, output miso, output data_ready_line);
  modport mst (output sclk, output cs_n, output mosi, input miso, input data_ready_line);
endinterface

//--- rtl/isp_master.sv
// master end: sends one 16-bit frame per user request and returns the reply
// assumes the device end samples the link on its own clock
`timescale 1ns/10ps

module isp_master
  (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // serial link
    isp_link_if.mst link,
    // user request
    input wire logic req_valid,
    input wire logic [15:0] req_word,
    output logic req_ready,
    // user answer
    output logic resp_valid,
    output logic [15:0] resp_word,
    output logic drdy_pulse
  );
  import isp_pkg::*;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  isp_mstate_t state_ff;
  logic [8:0] wait_ff;      // cycles left in the present phase
  logic [3:0] bit_ff;       // bits left after this one
  logic [15:0] tx_ff;       // frame being sent
  logic [15:0] rx_ff;       // reply being gathered
  logic sclk_ff;
  logic cs_n_ff;
  logic mosi_ff;
  logic resp_valid_ff;
  logic [1:0] miso_sync_ff; // [0] read only by [1]
  logic [1:0] drdy_sync_ff;
  logic drdy_prev_ff;
  logic drdy_pulse_ff;
  logic req_ready_ff;       // mirrors the idle state

  // clock divided from mclk keeps the link at or under its rate limit
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_ff <= ISP_M_IDLE;
      wait_ff <= 9'h0;
      bit_ff <= 4'h0;
      tx_ff <= 16'h0000;
      rx_ff <= 16'h0000;
      sclk_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
      req_ready_ff <= 1'b1;
      resp_valid_ff <= 1'b0;
    end
    else
    begin
      resp_valid_ff <= 1'b0;
      unique case (state_ff)
        ISP_M_IDLE:
        begin
          if (req_valid)
          begin
            tx_ff <= req_word;
            cs_n_ff <= 1'b0;  // held low for the whole frame
            wait_ff <= 9'(CS_SETUP_CYCLES - 1);
            bit_ff <= 4'hF;
            req_ready_ff <= 1'b0;
            state_ff <= ISP_M_SETUP;
          end
        end
        ISP_M_SETUP:
        begin
          if (wait_ff == 9'h0)
          begin
            sclk_ff <= 1'b0;             // falling edge: present next bit
            mosi_ff <= tx_ff[15];        // msb first
            tx_ff <= {tx_ff[14:0], 1'b0};
            wait_ff <= 9'(SCLK_HALF_CYCLES - 1);
            state_ff <= ISP_M_LOW;
          end
          else
          begin
            wait_ff <= wait_ff - 9'h1;
          end
        end
        ISP_M_LOW:
        begin
          if (wait_ff == 9'h0)
          begin
            sclk_ff <= 1'b1;             // rising edge: both ends sample
            rx_ff <= {rx_ff[14:0], miso_sync_ff[1]};
            wait_ff <= 9'(SCLK_HALF_CYCLES - 1);
            state_ff <= ISP_M_HIGH;
          end
          else
          begin
            wait_ff <= wait_ff - 9'h1;
          end
        end
        ISP_M_HIGH:
        begin
          if (wait_ff != 9'h0)
          begin
            wait_ff <= wait_ff - 9'h1;
          end
          else if (bit_ff == 4'h0)
          begin
            cs_n_ff <= 1'b1;             // frame of exactly sixteen clocks
            resp_valid_ff <= 1'b1;
            wait_ff <= 9'(STALL_CYCLES - 1);
            state_ff <= ISP_M_STALL;
          end
          else
          begin
            sclk_ff <= 1'b0;
            mosi_ff <= tx_ff[15];
            tx_ff <= {tx_ff[14:0], 1'b0};
            bit_ff <= bit_ff - 4'h1;
            wait_ff <= 9'(SCLK_HALF_CYCLES - 1);
            state_ff <= ISP_M_LOW;
          end
        end
        ISP_M_STALL:
        begin
          // gap lets the device settle before the next command
          if (wait_ff == 9'h0)
          begin
            req_ready_ff <= 1'b1;
            state_ff <= ISP_M_IDLE;
          end
          else
          begin
            wait_ff <= wait_ff - 9'h1;
          end
        end
        default:
        begin
          req_ready_ff <= 1'b1;
          state_ff <= ISP_M_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // input synchronisers and data-ready edge
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      miso_sync_ff <= 2'h0;
      drdy_sync_ff <= 2'h0;
      drdy_prev_ff <= 1'b0;
      drdy_pulse_ff <= 1'b0;
    end
    else
    begin
      miso_sync_ff <= {miso_sync_ff[0], link.miso};
      drdy_sync_ff <= {drdy_sync_ff[0], link.data_ready_line};
      drdy_prev_ff <= drdy_sync_ff[1];
      drdy_pulse_ff <= drdy_sync_ff[1] && !drdy_prev_ff;
    end
  end

  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = mosi_ff;
  assign req_ready = req_ready_ff;
  assign resp_valid = resp_valid_ff;
  assign resp_word = rx_ff;
  assign drdy_pulse = drdy_pulse_ff;

endmodule

//--- verification/isp_link_monitor.sv
// checker for the serial link joining the device end and the master end
// assumes one instance beside the link interface, all in the mclk domain
`timescale 1ns/10ps

module isp_link_monitor
  #(
    parameter int SAMPLE_CYC = isp_pkg::SAMPLE_CYCLES // sample period in mclk
  )
  (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic data_ready_line
  );
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic sclk_q_ff; // sclk one cycle ago
  logic [4:0] rise_ff; // sclk rises seen in this frame
  int gap_ff; // cycles since the last data-ready rise
  logic seen_ff; // first rise seen, so a period can be judged

  // count rises inside a frame; a high chip select clears the count
  always_ff @(posedge mclk)
  begin
    sclk_q_ff <= sclk;
    if (reset || cs_n)
      rise_ff <= 5'h00;
    else if (sclk && !sclk_q_ff)
      rise_ff <= rise_ff + 5'h01;
  end

  // time between data-ready pulses; the first one has no reference
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      gap_ff <= 0;
      seen_ff <= 1'b0;
    end
    else if ($rose(data_ready_line))
    begin
      gap_ff <= 1;
      seen_ff <= 1'b1;
    end
    else
      gap_ff <= gap_ff + 1;
  end

  // ------------------------------------------------------------
  // link rules
  // ------------------------------------------------------------
  AST_SCLK_IDLE: assert property (cs_n |-> sclk)
    else $error("serial clock not idle high");
  AST_CS_SETUP: assert property ($fell(cs_n) |-> sclk ##1 sclk)
    else $error("serial clock moved too soon after select");
  AST_HALF_LOW: assert property ($fell(sclk) |-> ##10 $rose(sclk))
    else $error("serial clock low phase wrong");
  AST_MOSI_HOLD: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(mosi))
    else $error("data in moved while clock high");
  AST_MISO_FALL: assert property ($changed(miso) && !cs_n && !$past(cs_n) |-> !sclk)
    else $error("data out moved while clock high");
  AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_ff == 5'h10)
    else $error("frame not sixteen clocks");
  AST_DRDY_WIDTH: assert property ($rose(data_ready_line) |-> data_ready_line[*8] ##1 !data_ready_line)
    else $error("data ready width wrong");
  AST_DRDY_PERIOD: assert property ($rose(data_ready_line) && seen_ff |-> gap_ff == SAMPLE_CYC)
    else $error("sample period wrong");
endmodule

//--- verification/inertial_sensor_spi_register_port_test.sv
// self-checking bench: master end and device end joined by one link
// assumes the shortened sample and backup counts set below
`timescale 1ns/10ps

module inertial_sensor_spi_register_port_test;
  import isp_pkg::*;
  localparam int SMP = 200; // shortened sample period
  localparam int BKP = 1000; // backup outlasts one frame, so a second one hits busy
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic aux_in = 1'b0; // aux pin, quiet until the sync test
  logic req_valid = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic aux_out, aux_oe_n, backup_busy, req_ready, resp_valid, drdy_pulse;
  logic [15:0] resp_word, sample_count;
  int n_fail = 0;
  int n_checks = 0;
  int n_drdy = 0; // data-ready pulses seen by the master
  logic [15:0] mem [32]; // model of the register words
  logic prev_rd = 1'b0; // last frame was a read command
  logic [6:0] prev_a = 7'h00; // its address
  logic [31:0] rng = 32'h63; // xorshift state

  always #12.5 mclk = ~mclk;

  // ------------------------------------------------------------
  // the two ends and the checker
  // ------------------------------------------------------------
  isp_link_if isp_link_if_i ();
  isp_device #(.SAMPLE_CYC(SMP), .BACKUP_CYC(BKP)) isp_device_i (.mclk(mclk), .reset(reset),
    .link(isp_link_if_i), .aux_in(aux_in), .aux_out(aux_out), .aux_oe_n(aux_oe_n),
    .backup_busy(backup_busy), .sample_count(sample_count));
  isp_master isp_master_i (.mclk(mclk), .reset(reset), .link(isp_link_if_i),
    .req_valid(req_valid), .req_word(req_word), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_word(resp_word), .drdy_pulse(drdy_pulse));
  isp_link_monitor #(.SAMPLE_CYC(SMP)) isp_link_monitor_i (.mclk(mclk), .reset(reset),
    .sclk(isp_link_if_i.sclk), .cs_n(isp_link_if_i.cs_n), .mosi(isp_link_if_i.mosi),
    .miso(isp_link_if_i.miso), .data_ready_line(isp_link_if_i.data_ready_line));

  // count pulses as the master reports them
  always @(posedge mclk)
    if (drdy_pulse === 1'b1)
      n_drdy++;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // a wait that ran out counts as a mismatch and ends the run
  task automatic die;
    n_fail++;
    report_and_stop();
  endtask

  // one frame through the master, reply judged against the model
  task automatic xfer(input logic [15:0] w);
    int i;
    logic [15:0] exp;
    for (i = 0; i < 1000 && req_ready !== 1'b1; i++)
      @(negedge mclk);
    if (i == 1000) die();
    req_valid = 1'b1;
    req_word = w;
    @(negedge mclk);
    req_valid = 1'b0;
    for (i = 0; i < 400 && resp_valid !== 1'b1; i++)
      @(negedge mclk);
    if (i == 400) die();
    // a write or an unmapped place answers zero
    exp = (prev_rd && !prev_a[6] && prev_a[5:1] != 5'h1F) ? mem[prev_a[5:1]] : 16'h0000;
    if (prev_rd && prev_a[6:1] == 6'h05)
      chk("x accel flags", {resp_word[15:14], 14'h0000}, 16'h8000);
    else
      chk("reply word", resp_word, exp);
    prev_rd = !w[15];
    prev_a = w[14:8];
    // byte writes land only in the writable range
    if (w[15] && w[13:8] >= 6'h1A && w[13:9] != 5'h1F)
    begin
      if (w[8])
        mem[w[13:9]][15:8] = w[7:0];
      else
        mem[w[13:9]][7:0] = w[7:0];
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int i;
    logic [15:0] w;
    logic [6:0] rs [6];
    rs = '{ADDR_MSC_CTRL, ADDR_SAMPLE_PERIOD, ADDR_SENS_AVG, 7'h21, ADDR_GLOBAL_CMD, 7'h45};
    for (i = 0; i < 32; i++)
      mem[i] = 16'h0000;
    mem[ADDR_MSC_CTRL[5:1]] = RST_MSC_CTRL;
    mem[ADDR_SAMPLE_PERIOD[5:1]] = RST_SAMPLE_PERIOD;
    mem[ADDR_SENS_AVG[5:1]] = RST_SENS_AVG;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    // reset values, an upper-byte read and unmapped places
    for (i = 0; i < 6; i++)
      xfer({1'b0, rs[i], 8'h00});
    $display("test reset reads done");
    // random byte writes; the rate and aux control words are spared
    repeat (24)
    begin
      rng = xs(rng);
      w = {2'b10, rng[13:0]};
      if (w[13:8] >= 6'h32 && w[13:8] <= 6'h37)
        w[12] = 1'b0;
      if (w[13:9] == 5'h1F)
        w[13] = 1'b0;
      xfer(w);
    end
    for (i = 0; i < 32; i++)
    begin
      rng = xs(rng);
      xfer({2'b00, i[4:0], rng[0], 8'h00});
    end
    $display("test write and read back done");
    // backup, a second request while busy, then the count
    xfer(BACKUP_FRAME);
    chk("backup busy", {15'h0000, backup_busy}, 16'h0001);
    xfer(BACKUP_FRAME);
    chk("still busy", {15'h0000, backup_busy}, 16'h0001);
    for (i = 0; i < 2000 && backup_busy !== 1'b0; i++)
      @(negedge mclk);
    if (i == 2000) die();
    for (i = 13; i < 32; i++)
      chk("backup image", isp_device_i.nv_ff[i], mem[i]);
    mem[0] = mem[0] + 16'h0001;
    xfer({1'b0, ADDR_BACKUP_COUNT, 8'h00});
    xfer(16'h0000);
    $display("test backup done");
    // aux line driven high through the control word
    chk("aux idle", {15'h0000, aux_oe_n}, 16'h0001);
    xfer(16'hB208);
    xfer(16'hB308);
    chk("aux drive", {14'h0000, aux_oe_n, aux_out}, 16'h0001);
    xfer(16'h3200);
    xfer(16'h0000);
    $display("test aux done");
    // sync mode: one aux edge, placed where the next internal sample would fall
    for (i = 0; i < 1000 && (req_ready !== 1'b1 || isp_link_monitor_i.gap_ff != 2); i++)
      @(negedge mclk);
    if (i == 1000) die();
    xfer(16'hB218);
    for (i = 0; i < 300 && isp_link_monitor_i.gap_ff != 197; i++)
      @(negedge mclk);
    if (i == 300) die();
    aux_in = 1'b1;
    chk("sync aux released", {15'h0000, aux_oe_n}, 16'h0001);
    // every sample reaches the master as one pulse
    for (i = 0; i < 300 && drdy_pulse !== 1'b1; i++)
      @(negedge mclk);
    if (i == 300) die();
    chk("sample count", sample_count, 16'(n_drdy + 1));
    $display("test samples done");
    report_and_stop();
  end
endmodule
